// ==== include/kbd_wake_pkg.sv ====
package kbd_wake_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [11:0] OFF_WAKE_STATUS = 12'h000;
	localparam logic [11:0] OFF_WAKE_ENABLE = 12'h004;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
	localparam logic [11:0] OFF_LINE_STATE = 12'h00c;
	localparam logic [11:0] OFF_GLOBAL_CFG = 12'h02c;
	localparam logic [11:0] OFF_GATE_CTRL = 12'h0f0;

	// Gate control fields
	localparam int GATE_KBD_LATCH_BIT = 3;
	localparam int GATE_MOUSE_LATCH_BIT = 4;
	localparam int GATE_KBD_ISO_BIT = 5;
	localparam int GATE_MOUSE_ISO_BIT = 6;

	// Global configuration fields
	localparam int GCFG_MCU_RST_BIT = 6;

	// Wake event bits, shared by status, enable and mask
	localparam int EV_W = 4;
	localparam int EV_KBD_IRQ = 0;
	localparam int EV_MOUSE_IRQ = 1;
	localparam int EV_KBD_DATA = 2;
	localparam int EV_MOUSE_DATA = 3;
	localparam int WEN_GLOBAL_BIT = 7;

	// Line state fields
	localparam int LS_MAIN_PWR_BIT = 0;
	localparam int LS_KBD_DATA_BIT = 1;
	localparam int LS_MOUSE_DATA_BIT = 2;
	localparam int LS_KBD_IRQ_BIT = 3;
	localparam int LS_MOUSE_IRQ_BIT = 4;
	localparam int LS_MCU_RST_BIT = 5;

	// Reset values
	localparam logic [7:0] GATE_CTRL_RST = 8'h00;
	localparam logic [7:0] GLOBAL_CFG_RST = 8'h00;
	localparam logic [7:0] WAKE_ENABLE_RST = 8'h00;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
	localparam logic [EV_W-1:0] WAKE_STATUS_RST = 4'h0;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

	// Active edge of the data lines for wake detection
	localparam logic ACTIVE_EDGE_FALL = 1'b1;

	typedef enum logic [2:0]
	{
		SEL_NONE,
		SEL_WAKE_STATUS,
		SEL_WAKE_ENABLE,
		SEL_IRQ_MASK,
		SEL_LINE_STATE,
		SEL_GLOBAL_CFG,
		SEL_GATE_CTRL
	} reg_sel_t;

endpackage

// ==== verilog/line_edge_sync.sv ====
`timescale 1ns/1ps
module line_edge_sync
	import kbd_wake_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Raw line
	input wire logic line_in,
	// Synchronised level and active edge
	output logic level,
	output logic edge_pulse
);

	logic sync1_ff;
	logic sync2_ff;
	logic prev_ff;

	// Lines idle high, so reset to high to avoid a false edge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_ff <= LINE_IDLE;
			sync2_ff <= LINE_IDLE;
			prev_ff <= LINE_IDLE;
		end
		else
		begin
			sync1_ff <= line_in;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	assign level = sync2_ff;
	assign edge_pulse = ACTIVE_EDGE_FALL ? (prev_ff & ~sync2_ff)
		: (~prev_ff & sync2_ff);

endmodule

// ==== verilog/kbd_mouse_wake_isolate.sv ====
// Notes on behaviour
// - Mouse latch select 0: raw AND latched mouse interrupt; 1: latched only.
// - Keyboard latch select 0: raw AND latched interrupt; 1: latched only.
// - Separate wake status for keyboard/mouse interrupt and data line edges.
// - Wake output needs status, its own enable and the global enable.
// - Interrupt-caused wake events only while main power is present.
// - Data-edge wake events occur under main power and standby alone.
// - Mouse isolate blocks mouse clock and data to microcontroller, not wake.
// - Keyboard isolate blocks keyboard lines to microcontroller, not wake.
// - Microcontroller reset bit holds until software writes it back to zero.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module kbd_mouse_wake_isolate
	import kbd_wake_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power state
	input wire logic main_power_good,
	// Microcontroller interrupt side
	input wire logic mcu_kbd_irq,
	input wire logic mcu_mouse_irq,
	input wire logic kbd_latch_clr,
	input wire logic mouse_latch_clr,
	output logic kbd_irq,
	output logic mouse_irq,
	// Port-side lines
	input wire logic kbd_clock_line,
	input wire logic kbd_data_line,
	input wire logic mouse_clock_line,
	input wire logic mouse_data_line,
	// Lines toward the microcontroller
	output logic mcu_kbd_clock,
	output logic mcu_kbd_data,
	output logic mcu_mouse_clock,
	output logic mcu_mouse_data,
	output logic mcu_reset,
	// Wake and interrupt
	output logic wake_pme,
	output logic irq
);

	function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		unique case (a)
			OFF_WAKE_STATUS: s = SEL_WAKE_STATUS;
			OFF_WAKE_ENABLE: s = SEL_WAKE_ENABLE;
			OFF_IRQ_MASK: s = SEL_IRQ_MASK;
			OFF_LINE_STATE: s = SEL_LINE_STATE;
			OFF_GLOBAL_CFG: s = SEL_GLOBAL_CFG;
			OFF_GATE_CTRL: s = SEL_GATE_CTRL;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction

	logic [7:0] gate_ctrl_ff;
	logic [7:0] global_cfg_ff;
	logic [7:0] wake_enable_ff;
	logic [EV_W-1:0] irq_mask_ff;
	logic [EV_W-1:0] wake_status_ff;
	logic [EV_W-1:0] nxt_wake_status;
	logic [EV_W-1:0] status_cap_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic pslverr_ff;
	logic kbd_latch_ff;
	logic mouse_latch_ff;
	logic kbd_raw_prev_ff;
	logic mouse_raw_prev_ff;
	logic kbd_irq_ff;
	logic mouse_irq_ff;
	logic mcu_kbd_clock_ff;
	logic mcu_kbd_data_ff;
	logic mcu_mouse_clock_ff;
	logic mcu_mouse_data_ff;
	logic wake_pme_ff;
	logic irq_ff;
	logic kbd_clk_s;
	logic kbd_dat_s;
	logic mouse_clk_s;
	logic mouse_dat_s;
	logic kbd_dat_edge;
	logic mouse_dat_edge;
	logic kbd_raw_rise;
	logic mouse_raw_rise;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] clr_bits;
	logic setup;
	logic access;
	logic wr_en;
	reg_sel_t sel;
	logic [DATA_W-1:0] rd_mux;

	// Port-side line synchronisers
	line_edge_sync u_kbd_clk
	(
		.clk(clk),
		.arst_n(arst_n),
		.line_in(kbd_clock_line),
		.level(kbd_clk_s),
		.edge_pulse()
	);

	line_edge_sync u_kbd_dat
	(
		.clk(clk),
		.arst_n(arst_n),
		.line_in(kbd_data_line),
		.level(kbd_dat_s),
		.edge_pulse(kbd_dat_edge)
	);

	line_edge_sync u_mouse_clk
	(
		.clk(clk),
		.arst_n(arst_n),
		.line_in(mouse_clock_line),
		.level(mouse_clk_s),
		.edge_pulse()
	);

	line_edge_sync u_mouse_dat
	(
		.clk(clk),
		.arst_n(arst_n),
		.line_in(mouse_data_line),
		.level(mouse_dat_s),
		.edge_pulse(mouse_dat_edge)
	);

	// Bus phase decode
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_en = access & pwrite & pstrb[0];
	assign sel = decode_reg(paddr);
	assign pready = 1'b1;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	always_comb
	begin
		rd_mux = RDATA_ZERO;
		unique case (sel)
			SEL_WAKE_STATUS: rd_mux[EV_W-1:0] = wake_status_ff;
			SEL_WAKE_ENABLE: rd_mux[7:0] = wake_enable_ff;
			SEL_IRQ_MASK: rd_mux[EV_W-1:0] = irq_mask_ff;
			SEL_LINE_STATE:
			begin
				rd_mux[LS_MAIN_PWR_BIT] = main_power_good;
				rd_mux[LS_KBD_DATA_BIT] = kbd_dat_s;
				rd_mux[LS_MOUSE_DATA_BIT] = mouse_dat_s;
				rd_mux[LS_KBD_IRQ_BIT] = kbd_irq_ff;
				rd_mux[LS_MOUSE_IRQ_BIT] = mouse_irq_ff;
				rd_mux[LS_MCU_RST_BIT] = global_cfg_ff[GCFG_MCU_RST_BIT];
			end
			SEL_GLOBAL_CFG: rd_mux[7:0] = global_cfg_ff;
			SEL_GATE_CTRL: rd_mux[7:0] = gate_ctrl_ff;
			SEL_NONE: rd_mux = RDATA_ZERO;
		endcase
	end

	// Read data and error are captured in setup so both come from flops
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prdata_ff <= RDATA_ZERO;
			pslverr_ff <= 1'b0;
			status_cap_ff <= WAKE_STATUS_RST;
		end
		else if (setup)
		begin
			prdata_ff <= rd_mux;
			pslverr_ff <= (sel == SEL_NONE);
			status_cap_ff <= (sel == SEL_WAKE_STATUS && !pwrite)
				? wake_status_ff : WAKE_STATUS_RST;
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gate_ctrl_ff <= GATE_CTRL_RST;
			global_cfg_ff <= GLOBAL_CFG_RST;
			wake_enable_ff <= WAKE_ENABLE_RST;
			irq_mask_ff <= IRQ_MASK_RST;
		end
		else if (wr_en)
		begin
			unique case (sel)
				SEL_GATE_CTRL: gate_ctrl_ff <= pwdata[7:0];
				// Reset bit is level held, never self-clearing
				SEL_GLOBAL_CFG: global_cfg_ff <= pwdata[7:0];
				SEL_WAKE_ENABLE: wake_enable_ff <= pwdata[7:0];
				SEL_IRQ_MASK: irq_mask_ff <= pwdata[EV_W-1:0];
				default:
				begin
				end
			endcase
		end
	end

	// Microcontroller reset follows the held bit
	assign mcu_reset = global_cfg_ff[GCFG_MCU_RST_BIT];

	// Raw interrupt edge detection
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			kbd_raw_prev_ff <= 1'b0;
			mouse_raw_prev_ff <= 1'b0;
		end
		else
		begin
			kbd_raw_prev_ff <= mcu_kbd_irq;
			mouse_raw_prev_ff <= mcu_mouse_irq;
		end
	end

	assign kbd_raw_rise = mcu_kbd_irq & ~kbd_raw_prev_ff;
	assign mouse_raw_rise = mcu_mouse_irq & ~mouse_raw_prev_ff;

	// Interrupt latches; a new edge wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			kbd_latch_ff <= 1'b0;
			mouse_latch_ff <= 1'b0;
		end
		else
		begin
			if (kbd_raw_rise)
				kbd_latch_ff <= 1'b1;
			else if (kbd_latch_clr)
				kbd_latch_ff <= 1'b0;
			if (mouse_raw_rise)
				mouse_latch_ff <= 1'b1;
			else if (mouse_latch_clr)
				mouse_latch_ff <= 1'b0;
		end
	end

	// Interrupt outputs toward the host
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			kbd_irq_ff <= 1'b0;
			mouse_irq_ff <= 1'b0;
		end
		else
		begin
			kbd_irq_ff <= gate_ctrl_ff[GATE_KBD_LATCH_BIT] ? kbd_latch_ff
				: (mcu_kbd_irq & kbd_latch_ff);
			mouse_irq_ff <= gate_ctrl_ff[GATE_MOUSE_LATCH_BIT]
				? mouse_latch_ff
				: (mcu_mouse_irq & mouse_latch_ff);
		end
	end

	assign kbd_irq = kbd_irq_ff;
	assign mouse_irq = mouse_irq_ff;

	// Isolation toward the microcontroller; blocked lines sit at idle high
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mcu_kbd_clock_ff <= LINE_IDLE;
			mcu_kbd_data_ff <= LINE_IDLE;
			mcu_mouse_clock_ff <= LINE_IDLE;
			mcu_mouse_data_ff <= LINE_IDLE;
		end
		else
		begin
			mcu_kbd_clock_ff <= gate_ctrl_ff[GATE_KBD_ISO_BIT]
				? LINE_IDLE : kbd_clk_s;
			mcu_kbd_data_ff <= gate_ctrl_ff[GATE_KBD_ISO_BIT]
				? LINE_IDLE : kbd_dat_s;
			mcu_mouse_clock_ff <= gate_ctrl_ff[GATE_MOUSE_ISO_BIT]
				? LINE_IDLE : mouse_clk_s;
			mcu_mouse_data_ff <= gate_ctrl_ff[GATE_MOUSE_ISO_BIT]
				? LINE_IDLE : mouse_dat_s;
		end
	end

	assign mcu_kbd_clock = mcu_kbd_clock_ff;
	assign mcu_kbd_data = mcu_kbd_data_ff;
	assign mcu_mouse_clock = mcu_mouse_clock_ff;
	assign mcu_mouse_data = mcu_mouse_data_ff;

	// Wake events; data edges bypass isolation and need no main power
	always_comb
	begin
		events = '0;
		events[EV_KBD_IRQ] = kbd_raw_rise & main_power_good;
		events[EV_MOUSE_IRQ] = mouse_raw_rise & main_power_good;
		events[EV_KBD_DATA] = kbd_dat_edge;
		events[EV_MOUSE_DATA] = mouse_dat_edge;
	end

	// Read clears only the bits the reader saw, so fresh events survive
	assign clr_bits = (access && !pwrite && sel == SEL_WAKE_STATUS)
		? status_cap_ff : WAKE_STATUS_RST;
	assign nxt_wake_status = (wake_status_ff & ~clr_bits) | events;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			wake_status_ff <= WAKE_STATUS_RST;
		else
			wake_status_ff <= nxt_wake_status;
	end

	// Wake request and interrupt
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wake_pme_ff <= 1'b0;
			irq_ff <= 1'b0;
		end
		else
		begin
			wake_pme_ff <= wake_enable_ff[WEN_GLOBAL_BIT]
				& (|(nxt_wake_status & wake_enable_ff[EV_W-1:0]));
			irq_ff <= |(nxt_wake_status & irq_mask_ff);
		end
	end

	assign wake_pme = wake_pme_ff;
	assign irq = irq_ff;

endmodule

// ==== sim/ps2_port_model.sv ====
`timescale 1ns/1ps
module ps2_port_model
(
	// Clock and frame requests
	input wire logic clk,
	input wire logic kbd_act,
	input wire logic mouse_act,
	// Open-drain port lines, pulled up
	output logic kbd_clock_line = 1'b1,
	output logic kbd_data_line = 1'b1,
	output logic mouse_clock_line = 1'b1,
	output logic mouse_data_line = 1'b1
);
	// Clock only runs inside a frame; released lines go to the pull-up
	always_ff @(posedge clk)
	begin
		kbd_clock_line <= kbd_act ? ~kbd_clock_line : 1'b1;
		kbd_data_line <= !kbd_act;
		mouse_clock_line <= mouse_act ? ~mouse_clock_line : 1'b1;
		mouse_data_line <= !mouse_act;
	end
endmodule

// ==== sim/kbd_wake_props.sv ====
`timescale 1ns/1ps
module kbd_wake_props
	import kbd_wake_pkg::*;
(
	// Clock, reset and bus
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	// Watched pins
	input wire logic mcu_kbd_irq,
	input wire logic mouse_latch_clr,
	input wire logic kbd_irq,
	input wire logic mouse_irq,
	input wire logic kbd_data_line,
	input wire logic mcu_kbd_clock,
	input wire logic mcu_kbd_data,
	input wire logic mcu_mouse_clock,
	input wire logic mcu_mouse_data,
	input wire logic mcu_reset,
	input wire logic wake_pme
);
	logic [7:0] gate_ff;
	logic [7:0] cfg_ff;
	logic [7:0] wen_ff;
	logic wr_go;
	assign wr_go = psel && penable && pwrite && pstrb[0];
	// Shadows of the control registers, fed only by bus writes
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gate_ff <= 8'h00;
			cfg_ff <= 8'h00;
			wen_ff <= 8'h00;
		end
		else if (wr_go)
		begin
			if (paddr == OFF_GATE_CTRL)
				gate_ff <= pwdata[7:0];
			if (paddr == OFF_GLOBAL_CFG)
				cfg_ff <= pwdata[7:0];
			if (paddr == OFF_WAKE_ENABLE)
				wen_ff <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_latch_held;
		$past(gate_ff[4], 2) && $past(gate_ff[4]) && $past(mouse_irq)
			&& !$past(mouse_latch_clr, 2);
	endsequence
	property p_mouse_irq_latched;
		s_latch_held |-> mouse_irq;
	endproperty
	property p_kbd_irq_and;
		!$past(gate_ff[3]) && !$past(mcu_kbd_irq) |-> !kbd_irq;
	endproperty
	property p_kbd_iso;
		$past(gate_ff[5]) |-> mcu_kbd_clock && mcu_kbd_data;
	endproperty
	property p_mouse_iso;
		$past(gate_ff[6]) |-> mcu_mouse_clock && mcu_mouse_data;
	endproperty
	property p_kbd_pass;
		!$past(gate_ff[5]) |-> mcu_kbd_data == $past(kbd_data_line, 3);
	endproperty
	property p_mcu_rst;
		mcu_reset == cfg_ff[GCFG_MCU_RST_BIT];
	endproperty
	property p_pme_global;
		$rose(wake_pme) |-> $past(wen_ff[WEN_GLOBAL_BIT]);
	endproperty
	property p_pme_ind;
		$rose(wake_pme) |-> $past(|wen_ff[EV_W-1:0]);
	endproperty
	a_mouse_irq_latched: assert property (p_mouse_irq_latched)
		else $error("mouse latch lost");
	a_kbd_irq_and: assert property (p_kbd_irq_and)
		else $error("kbd irq without raw");
	a_kbd_iso: assert property (p_kbd_iso)
		else $error("kbd lines leak");
	a_mouse_iso: assert property (p_mouse_iso)
		else $error("mouse lines leak");
	a_kbd_pass: assert property (p_kbd_pass)
		else $error("kbd data not passed");
	a_mcu_rst: assert property (p_mcu_rst)
		else $error("mcu reset mismatch");
	a_pme_global: assert property (p_pme_global)
		else $error("wake without global");
	a_pme_ind: assert property (p_pme_ind)
		else $error("wake without enable");
endmodule
bind kbd_mouse_wake_isolate kbd_wake_props u_props (.clk, .arst_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .mcu_kbd_irq,
	.mouse_latch_clr, .kbd_irq, .mouse_irq, .kbd_data_line, .mcu_kbd_clock,
	.mcu_kbd_data, .mcu_mouse_clock, .mcu_mouse_data, .mcu_reset, .wake_pme);

// ==== sim/kbd_mouse_wake_isolate_bench.sv ====
`timescale 1ns/1ps
module kbd_mouse_wake_isolate_bench import kbd_wake_pkg::*;;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata, rd;
	logic [3:0] pstrb = 4'h1;
	logic pready, pslverr, err, main_power_good = 1;
	logic mcu_kbd_irq = 0, mcu_mouse_irq = 0;
	logic kbd_latch_clr = 0, mouse_latch_clr = 0, kbd_act = 0, mouse_act = 0;
	logic kbd_irq, mouse_irq, mcu_reset, wake_pme, irq;
	logic kbd_clock_line, kbd_data_line, mouse_clock_line, mouse_data_line;
	logic mcu_kbd_clock, mcu_kbd_data, mcu_mouse_clock, mcu_mouse_data;
	int mismatches = 0, checked = 0;
	always #25 clk = ~clk;
	ps2_port_model PORT (.clk, .kbd_act, .mouse_act, .kbd_clock_line,
		.kbd_data_line, .mouse_clock_line, .mouse_data_line);
	kbd_mouse_wake_isolate DUT (.clk, .arst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .main_power_good,
		.mcu_kbd_irq, .mcu_mouse_irq, .kbd_latch_clr, .mouse_latch_clr,
		.kbd_irq, .mouse_irq, .kbd_clock_line, .kbd_data_line,
		.mouse_clock_line, .mouse_data_line, .mcu_kbd_clock, .mcu_kbd_data,
		.mcu_mouse_clock, .mcu_mouse_data, .mcu_reset, .wake_pme, .irq);
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Entered right after an edge; idle edge at the end keeps psel clean
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// Only the watchdog ends a stalled access
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic t_regs;
		apb(0, OFF_GATE_CTRL, 0);
		chk(rd, 32'h0000_0000);
		apb(1, OFF_GATE_CTRL, 32'h0000_00a5);
		apb(0, OFF_GATE_CTRL, 0);
		chk(rd, 32'h0000_00a5);
		apb(0, 12'h010, 0);
		chk({rd[30:0], err}, 32'h0000_0001);
		apb(1, OFF_GATE_CTRL, 0);
	endtask
	task automatic t_latch;
		for (int s = 0; s < 2; s++)
		begin
			apb(1, OFF_GATE_CTRL, s ? 32'h0000_0018 : 32'h0000_0000);
			mcu_kbd_irq <= 1;
			mcu_mouse_irq <= 1;
			wt(3);
			chk({kbd_irq, mouse_irq}, 32'h0000_0003);
			mcu_kbd_irq <= 0;
			mcu_mouse_irq <= 0;
			wt(3);
			chk(kbd_irq, s);
			chk(mouse_irq, s);
			kbd_latch_clr <= 1;
			mouse_latch_clr <= 1;
			wt(1);
			kbd_latch_clr <= 0;
			mouse_latch_clr <= 0;
			wt(3);
			chk({kbd_irq, mouse_irq}, 32'h0000_0000);
		end
	endtask
	task automatic t_wake;
		apb(0, OFF_WAKE_STATUS, 0);
		apb(1, OFF_IRQ_MASK, 32'h0000_000f);
		apb(1, OFF_WAKE_ENABLE, 32'h0000_000c);
		main_power_good <= 0;
		mcu_kbd_irq <= 1;
		kbd_act <= 1;
		wt(2);
		kbd_act <= 0;
		wt(4);
		chk({wake_pme, irq}, 32'h0000_0001);
		apb(1, OFF_WAKE_ENABLE, 32'h0000_008c);
		// Wake output is launched on the idle edge; look one edge later
		wt(1);
		chk(wake_pme, 1);
		apb(0, OFF_WAKE_STATUS, 0);
		chk(rd, 32'h0000_0004);
		chk({wake_pme, irq}, 32'h0000_0000);
		mcu_kbd_irq <= 0;
		main_power_good <= 1;
		mcu_mouse_irq <= 1;
		mouse_act <= 1;
		wt(2);
		mouse_act <= 0;
		mcu_mouse_irq <= 0;
		wt(4);
		apb(0, OFF_WAKE_STATUS, 0);
		chk(rd, 32'h0000_000a);
	endtask
	task automatic t_iso;
		apb(1, OFF_IRQ_MASK, 0);
		apb(1, OFF_GATE_CTRL, 32'h0000_0060);
		kbd_act <= 1;
		mouse_act <= 1;
		wt(5);
		chk({mcu_kbd_data, mcu_kbd_clock}, 32'h0000_0003);
		chk({mcu_mouse_data, mcu_mouse_clock}, 32'h0000_0003);
		chk(irq, 0);
		kbd_act <= 0;
		mouse_act <= 0;
		wt(4);
		apb(0, OFF_WAKE_STATUS, 0);
		chk(rd, 32'h0000_000c);
		apb(1, OFF_GATE_CTRL, 0);
		kbd_act <= 1;
		mouse_act <= 1;
		wt(5);
		chk(mcu_kbd_data, 0);
		chk({mcu_kbd_clock, mcu_mouse_clock, mcu_mouse_data}, 0);
		kbd_act <= 0;
		mouse_act <= 0;
		wt(4);
		apb(0, OFF_WAKE_STATUS, 0);
	endtask
	task automatic t_rst;
		apb(1, OFF_GATE_CTRL, 32'h0000_0060);
		wt(4);
		apb(1, OFF_GATE_CTRL, 0);
		chk(mcu_reset, 0);
		apb(1, OFF_GATE_CTRL, 32'h0000_0060);
		main_power_good <= 0;
		wt(10);
		main_power_good <= 1;
		apb(1, OFF_GATE_CTRL, 0);
		apb(1, OFF_GLOBAL_CFG, 32'h0000_0040);
		wt(20);
		chk(mcu_reset, 1);
		apb(0, OFF_LINE_STATE, 0);
		chk(rd, 32'h0000_0027);
		apb(1, OFF_GLOBAL_CFG, 32'h0000_0000);
		chk(mcu_reset, 0);
	endtask
	task automatic tally_and_finish;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		wt(12);
		arst_n <= 1;
		wt(1);
		t_regs;
		t_latch;
		t_wake;
		t_iso;
		t_rst;
		tally_and_finish;
	end
	// Whole run is about 175 cycles; this is 4000 cycles, over twenty times that
	initial
	begin
		#200_000;
		mismatches++;
		tally_and_finish;
	end
endmodule
